// ---- design/ecc_ctrl.sv ----
// Functional notes
// - Mode field zero turns the unit off and resets internal state.
// - Codes 0100..0111: falling, rising, 4th rising, 16th rising capture.
// - Compare match toggles, sets or clears output and sets flag.
// - Software-interrupt compare sets flag, leaves pin alone.
// - Special event sets flag, resets timer, starts converter if enabled.
// - Codes 1100..1111 select PWM; low bits set pair A/C, B/D polarity.
// - Outside PWM, steering ignored; A is the pin, B/C/D released.
// - PWM steering: single, full forward, half bridge, full reverse.
// - Duty low bits extend the low byte into a 10-bit duty value.
// - Qualified capture copies the whole 16-bit timer into the pair.
// - Flag set on every capture, only software clears it.
// - A new capture overwrites the old value, no overrun guard.
// - Edge detector watches pad level, even while pin is driven.
// - Prescaler held clear when off, outside capture, or on reset.
// - Prescaler setting changes do not clear the prescaler counter.
// - A capture mode change may give a spurious flag.
// - Compare pair is compared continuously against the timer.
// - Special event at once; timer reset at next timer clock edge.
// - Control written zero forces compare latch low.
//
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module ecc_ctrl (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Timer one
	input wire logic [15:0] timer_one_count,
	input wire logic timer_tick,
	output logic timer_reset,
	// Converter trigger
	input wire logic adc_enabled,
	output logic adc_start,
	// Pins and PWM
	input wire logic capture_compare_pin,
	input wire logic pwm_wave,
	output ecc_pkg::ecc_pins_t pins,
	output logic [9:0] duty_value,
	// Status
	output logic unit_interrupt_flag
);
	import ecc_pkg::*;

	logic [7:0] enhanced_timing_unit_control;
	logic [7:0] capture_compare_low_byte;
	logic [7:0] capture_compare_high_byte;
	logic dp_valid;
	logic dp_write;
	logic [7:0] dp_addr;
	logic rd_pend;
	logic [7:0] rd_addr;
	logic pin_meta;
	logic pin_sync;
	logic pin_prev;
	logic [3:0] presc;
	logic cmp_latch;
	logic match_prev;
	logic pend_reset;

	// Control field decode
	ecc_mode_t unit_mode_select;
	ecc_steer_t output_steering_config;
	logic [1:0] duty_low_bits;
	assign unit_mode_select = ecc_mode_t'(enhanced_timing_unit_control[ECC_MODE_HI:0]);
	assign output_steering_config = ecc_steer_t'(enhanced_timing_unit_control[ECC_STEER_HI:ECC_STEER_LO]);
	assign duty_low_bits = enhanced_timing_unit_control[ECC_DUTY_HI:ECC_DUTY_LO];

	// Mode class decode
	wire is_off = unit_mode_select == ECC_OFF;
	wire is_capture = unit_mode_select[3:2] == 2'h1;
	wire is_pwm = unit_mode_select[3:2] == 2'h3;
	wire is_special = unit_mode_select == ECC_CMP_SPECIAL;
	wire cmp_drive = unit_mode_select == ECC_CMP_TOGGLE
		|| unit_mode_select == ECC_CMP_SET
		|| unit_mode_select == ECC_CMP_CLR;
	wire is_compare = cmp_drive || unit_mode_select == ECC_CMP_SWI || is_special;

	// Bus address phase and write strobes
	wire accept = hsel && hready && htrans == ECC_HTRANS_NONSEQ;
	wire mapped = dp_addr == ECC_ADDR_CTRL || dp_addr == ECC_ADDR_CCLO
		|| dp_addr == ECC_ADDR_CCHI || dp_addr == ECC_ADDR_STAT;
	wire wr_en = dp_valid && dp_write && mapped;
	wire wr_ctrl = wr_en && dp_addr == ECC_ADDR_CTRL;
	wire wr_cclo = wr_en && dp_addr == ECC_ADDR_CCLO;
	wire wr_cchi = wr_en && dp_addr == ECC_ADDR_CCHI;
	wire flag_clr = wr_en && dp_addr == ECC_ADDR_STAT && hwdata[ECC_STAT_FLAG];
	wire [31:0] rd_mux =
		rd_addr == ECC_ADDR_CTRL ? {24'h000000, enhanced_timing_unit_control} :
		rd_addr == ECC_ADDR_CCLO ? {24'h000000, capture_compare_low_byte} :
		rd_addr == ECC_ADDR_CCHI ? {24'h000000, capture_compare_high_byte} :
		rd_addr == ECC_ADDR_STAT ? {31'h0, unit_interrupt_flag} : 32'h00000000;

	// Edge detect on the synchronised pad level
	wire rise = pin_sync && !pin_prev;
	wire fall = !pin_sync && pin_prev;

	// Capture qualification by prescaler setting
	wire cap_event = is_capture && (
		unit_mode_select == ECC_CAP_FALL ? fall :
		unit_mode_select == ECC_CAP_RISE ? rise :
		unit_mode_select == ECC_CAP_RISE4 ? rise && presc[1:0] == ECC_PRESC_4 :
		rise && presc == ECC_PRESC_16);
	wire [3:0] next_presc = !is_capture ? 4'h0 :
		rise ? 4'(presc + 4'h1) : presc;

	// Continuous compare, acted on once per match
	wire cmp_match = timer_one_count
		== {capture_compare_high_byte, capture_compare_low_byte};
	wire cmp_hit = is_compare && cmp_match && !match_prev;

	// Compare output latch
	wire next_cmp_latch = is_off ? 1'b0 :
		!cmp_hit ? cmp_latch :
		unit_mode_select == ECC_CMP_TOGGLE ? !cmp_latch :
		unit_mode_select == ECC_CMP_SET ? 1'b1 :
		unit_mode_select == ECC_CMP_CLR ? 1'b0 : cmp_latch;

	// Sticky flag, set beats clear
	wire flag_set = cap_event || cmp_hit;
	wire next_flag = flag_set || (unit_interrupt_flag && !flag_clr);

	// Reset request stands from the match until the next timer clock edge
	wire next_pend = is_special && cmp_match
		&& (cmp_hit || (pend_reset && !timer_tick));

	// PWM steering and polarity
	wire w = pwm_wave;
	wire [3:0] pwm_raw =
		output_steering_config == ECC_STEER_SINGLE ? {3'h0, w} :
		output_steering_config == ECC_STEER_FWD ? {w, 3'h1} :
		output_steering_config == ECC_STEER_HALF ? {2'h0, !w, w} :
		{1'b0, 1'b1, w, 1'b0};
	wire [3:0] pwm_drv =
		output_steering_config == ECC_STEER_SINGLE ? 4'h1 :
		output_steering_config == ECC_STEER_HALF ? 4'h3 : 4'hF;
	wire pol_ac = unit_mode_select[1];
	wire pol_bd = unit_mode_select[0];
	wire [3:0] pol_mask = {pol_bd, pol_ac, pol_bd, pol_ac};
	ecc_pins_t next_pins;
	assign next_pins.level = is_pwm ? (pwm_raw ^ pol_mask) & pwm_drv
		: {3'h0, cmp_latch && cmp_drive};
	assign next_pins.oe_n = is_pwm ? ~pwm_drv : {3'h7, !cmp_drive};
	wire [9:0] next_duty = is_pwm ? {capture_compare_low_byte, duty_low_bits} : 10'h000;

	// Bus data phase tracking
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr <= 8'h00;
		end else if (hready) begin
			dp_valid <= accept;
			dp_write <= hwrite;
			dp_addr <= haddr[7:0];
		end
	end

	// Read path, one wait state
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
			rd_pend <= 1'b0;
			rd_addr <= 8'h00;
		end else begin
			hresp <= 1'b0;
			rd_pend <= accept && !hwrite;
			rd_addr <= haddr[7:0];
			hreadyout <= !(accept && !hwrite);
			if (rd_pend) begin
				hrdata <= rd_mux;
			end
		end
	end

	// Control register
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			enhanced_timing_unit_control <= ECC_CTRL_RESET;
		end else if (wr_ctrl) begin
			enhanced_timing_unit_control <= hwdata[7:0];
		end
	end

	// Capture/compare pair, capture wins over a write
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			capture_compare_low_byte <= ECC_CC_RESET;
			capture_compare_high_byte <= ECC_CC_RESET;
		end else if (cap_event) begin
			capture_compare_low_byte <= timer_one_count[7:0];
			capture_compare_high_byte <= timer_one_count[15:8];
		end else begin
			if (wr_cclo) begin
				capture_compare_low_byte <= hwdata[7:0];
			end
			if (wr_cchi) begin
				capture_compare_high_byte <= hwdata[7:0];
			end
		end
	end

	// Pin synchroniser and edge history
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			pin_prev <= 1'b0;
		end else begin
			pin_meta <= capture_compare_pin;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// Unit state; prescaler, compare latch and reset request cleared when the mode field is zero
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			presc <= 4'h0;
			cmp_latch <= 1'b0;
			match_prev <= 1'b0;
			pend_reset <= 1'b0;
		end else begin
			presc <= next_presc;
			cmp_latch <= next_cmp_latch;
			match_prev <= cmp_match;
			pend_reset <= next_pend;
		end
	end

	// Registered outputs
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			unit_interrupt_flag <= 1'b0;
			timer_reset <= 1'b0;
			adc_start <= 1'b0;
			pins <= '{level: 4'h0, oe_n: 4'hF};
			duty_value <= 10'h000;
		end else begin
			unit_interrupt_flag <= next_flag;
			timer_reset <= next_pend;
			adc_start <= cmp_hit && is_special && adc_enabled;
			pins <= next_pins;
			duty_value <= next_duty;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_flag_on_capture: assert property (cap_event |=> unit_interrupt_flag)
		else $error("flag not set after capture");
	a_flag_sticky: assert property (unit_interrupt_flag && !flag_clr |=> unit_interrupt_flag)
		else $error("flag dropped without software clear");
	a_capture_copy: assert property (cap_event |=>
		{capture_compare_high_byte, capture_compare_low_byte} == $past(timer_one_count))
		else $error("capture pair does not hold timer value");
	a_fall_edge_only: assert property (cap_event && unit_mode_select == ECC_CAP_FALL
		|-> $past(pin_sync) && !pin_sync)
		else $error("falling capture without falling edge");
	a_presc_held: assert property (!is_capture |=> presc == 4'h0)
		else $error("prescaler not held clear");
	a_off_latch_low: assert property (is_off |=> !cmp_latch && pins.level[0] == 1'b0)
		else $error("compare latch not low when off");
	a_toggle_match: assert property (cmp_hit && unit_mode_select == ECC_CMP_TOGGLE
		|=> cmp_latch != $past(cmp_latch))
		else $error("toggle mode did not toggle");
	a_swi_pin_free: assert property (unit_mode_select == ECC_CMP_SWI |=> pins.oe_n[0])
		else $error("pin driven in software interrupt mode");
	a_special_trigger: assert property (cmp_hit && is_special && adc_enabled |=> adc_start)
		else $error("no converter start on special event");
	a_timer_reset_tick: assert property (cmp_hit && is_special
		|=> timer_reset)
		else $error("timer reset not requested after special event");
	a_port_release: assert property (!is_pwm |=> pins.oe_n[3:1] == 3'h7)
		else $error("B/C/D driven outside PWM");
	a_pwm_single: assert property (is_pwm && output_steering_config == ECC_STEER_SINGLE
		|=> pins.oe_n == 4'hE)
		else $error("single output steering wrong");
	a_duty_value: assert property (is_pwm |=> duty_value ==
		{$past(capture_compare_low_byte), $past(duty_low_bits)})
		else $error("duty value mismatch");

	// Capture path checks
	a_rise_edge_only: assert property (cap_event && unit_mode_select == ECC_CAP_RISE
		|-> !$past(pin_sync) && pin_sync)
		else $error("rising capture without rising edge");
	a_sync_depth: assert property (rise |-> $past(capture_compare_pin, 2))
		else $error("edge seen before two synchroniser stages");
	a_presc_kept: assert property (is_capture && !rise ##1 is_capture
		|-> presc == $past(presc))
		else $error("prescaler changed without an edge");
	a_flag_clear: assert property (flag_clr && !flag_set |=> !unit_interrupt_flag)
		else $error("flag not cleared by software");

	// Compare path checks
	a_cmp_flag: assert property (cmp_hit |=> unit_interrupt_flag)
		else $error("flag not set on compare match");
	a_set_match: assert property (cmp_hit && unit_mode_select == ECC_CMP_SET
		|=> cmp_latch)
		else $error("set mode did not set the latch");
	a_clear_match: assert property (cmp_hit && unit_mode_select == ECC_CMP_CLR
		|=> !cmp_latch)
		else $error("clear mode did not clear the latch");
	a_special_pin_free: assert property (is_special |=> pins.oe_n[0])
		else $error("pin driven in special event mode");
	a_reset_once: assert property (timer_reset && timer_tick |=> !timer_reset)
		else $error("timer reset request outlived its timer edge");
	a_adc_quiet: assert property (!adc_enabled |=> !adc_start)
		else $error("converter start while converter disabled");

	// PWM output checks
	a_pwm_forward: assert property (is_pwm && output_steering_config == ECC_STEER_FWD
		|=> pins.oe_n == 4'h0 && pins.level[0] == !$past(pol_ac))
		else $error("forward steering wrong");
	a_pwm_half: assert property (is_pwm && output_steering_config == ECC_STEER_HALF
		|=> pins.oe_n == 4'hC)
		else $error("half bridge steering wrong");
	a_pwm_polarity: assert property (is_pwm && output_steering_config == ECC_STEER_SINGLE
		|=> pins.level[0] == ($past(pwm_wave) ^ $past(pol_ac)))
		else $error("single output polarity wrong");
	a_duty_zero: assert property (!is_pwm |=> duty_value == 10'h000)
		else $error("duty value not zero outside PWM");

	c_capture: cover property (cap_event && unit_mode_select == ECC_CAP_RISE16);
	c_timer_reset: cover property (timer_reset);
	c_pwm_reverse: cover property (is_pwm && output_steering_config == ECC_STEER_REV);
	c_flag_clear: cover property (unit_interrupt_flag ##1 !unit_interrupt_flag);
endmodule
`default_nettype wire

// ---- design/ecc_pkg.sv ----
package ecc_pkg;
	// Register byte addresses (low address bits)
	localparam logic [7:0] ECC_ADDR_CTRL = 8'h00;
	localparam logic [7:0] ECC_ADDR_CCLO = 8'h04;
	localparam logic [7:0] ECC_ADDR_CCHI = 8'h08;
	localparam logic [7:0] ECC_ADDR_STAT = 8'h0C;
	// Reset values
	localparam logic [7:0] ECC_CTRL_RESET = 8'h00;
	localparam logic [7:0] ECC_CC_RESET = 8'h00;
	// Control field positions
	localparam int ECC_STEER_HI = 7;
	localparam int ECC_STEER_LO = 6;
	localparam int ECC_DUTY_HI = 5;
	localparam int ECC_DUTY_LO = 4;
	localparam int ECC_MODE_HI = 3;
	// Status field position
	localparam int ECC_STAT_FLAG = 0;
	// Prescaler terminal counts
	localparam logic [1:0] ECC_PRESC_4 = 2'h3;
	localparam logic [3:0] ECC_PRESC_16 = 4'hF;
	// AHB transfer type
	localparam logic [1:0] ECC_HTRANS_NONSEQ = 2'h2;

	typedef enum logic [3:0] {
		ECC_OFF = 4'h0, ECC_RSV1 = 4'h1, ECC_CMP_TOGGLE = 4'h2, ECC_RSV3 = 4'h3,
		ECC_CAP_FALL = 4'h4, ECC_CAP_RISE = 4'h5, ECC_CAP_RISE4 = 4'h6,
		ECC_CAP_RISE16 = 4'h7, ECC_CMP_SET = 4'h8, ECC_CMP_CLR = 4'h9,
		ECC_CMP_SWI = 4'hA, ECC_CMP_SPECIAL = 4'hB, ECC_PWM_HH = 4'hC,
		ECC_PWM_HL = 4'hD, ECC_PWM_LH = 4'hE, ECC_PWM_LL = 4'hF
	} ecc_mode_t;

	typedef enum logic [1:0] {
		ECC_STEER_SINGLE = 2'h0, ECC_STEER_FWD = 2'h1,
		ECC_STEER_HALF = 2'h2, ECC_STEER_REV = 2'h3
	} ecc_steer_t;

	// Pin group: bit 0 = A, 1 = B, 2 = C, 3 = D
	typedef struct packed {
		logic [3:0] level;
		logic [3:0] oe_n;
	} ecc_pins_t;
endpackage

// ---- test/ecc_partner.sv ----
`timescale 1ns/1ns
`default_nettype none
module ecc_partner (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Bench control
	input wire logic count_en,
	input wire logic load_en,
	input wire logic [15:0] load_val,
	input wire logic pin_req,
	input wire logic wave_req,
	// Design side
	input wire logic timer_reset,
	output logic [15:0] timer_one_count,
	output logic timer_tick,
	output logic capture_compare_pin,
	output logic pwm_wave
);
	// Timer on the system clock, one tick every other cycle
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			timer_one_count <= 16'h0000;
			timer_tick <= 1'h0;
		end else begin
			timer_tick <= count_en & ~timer_tick;
			if (load_en)
				timer_one_count <= load_val;
			else if (timer_reset && timer_tick)
				timer_one_count <= 16'h0000;
			else if (timer_tick)
				timer_one_count <= timer_one_count + 16'h0001;
		end
	end
	// Pin kept as an input, wave straight from the bench
	assign capture_compare_pin = pin_req;
	assign pwm_wave = wave_req;
endmodule
`default_nettype wire

// ---- test/enhanced_capture_compare_ctrl_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module enhanced_capture_compare_ctrl_tb_top;
	import ecc_pkg::*;
	logic sys_clk = 1'h0;
	logic reset = 1'h1;
	logic hsel = 1'h0, hwrite = 1'h0, count_en = 1'h0, load_en = 1'h0;
	logic pin_req = 1'h0, wave_req = 1'h0, adc_enabled = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
	logic [31:0] seed = 32'h52A1CA33;
	logic [1:0] htrans = 2'h0;
	logic [15:0] load_val = 16'h0, tval, tcount;
	logic hreadyout, hresp, timer_reset, timer_tick, adc_start, flag, ccp, wave, ac, bd, w;
	logic [9:0] duty_value;
	logic [7:0] cc_lo;
	logic [3:0] lv, oe;
	ecc_pins_t pins;
	int fail_count = 0, tests_run = 0, n_adc = 0, n_trst = 0, a0, t0, n, lvl;
	int cmp_modes[7] = '{9, 8, 2, 10, 11, 11, 2};

	// Clock and pulse counters
	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		n_adc <= n_adc + int'(adc_start === 1'h1);
		n_trst <= n_trst + int'(timer_reset === 1'h1);
	end

	ecc_ctrl i_dut (.sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer_one_count(tcount),
		.timer_tick(timer_tick), .timer_reset(timer_reset), .adc_enabled(adc_enabled),
		.adc_start(adc_start), .capture_compare_pin(ccp), .pwm_wave(wave), .pins(pins),
		.duty_value(duty_value), .unit_interrupt_flag(flag));
	ecc_partner i_far (.sys_clk(sys_clk), .reset(reset), .count_en(count_en),
		.load_en(load_en), .load_val(load_val), .pin_req(pin_req), .wave_req(wave_req),
		.timer_reset(timer_reset), .timer_one_count(tcount), .timer_tick(timer_tick),
		.capture_compare_pin(ccp), .pwm_wave(wave));

	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic wrap_up();
		if (fail_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic go(input int k);
		repeat (k) @(posedge sys_clk);
	endtask
	// Waits for hready high, bounded
	task automatic wait_rdy();
		int i;
		i = 0;
		do begin
			@(negedge sys_clk);
			i++;
		end while (hreadyout !== 1'h1 && i < 50);
		if (i >= 50) begin
			fail_count++;
			wrap_up();
		end
		@(posedge sys_clk);
	endtask
	// One single AHB transfer, read data left in q
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		hsel <= 1'h1;
		haddr <= {24'h0, a};
		htrans <= ECC_HTRANS_NONSEQ;
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wait_rdy();
		q = hrdata;
		chk("hresp", 0, hresp);
	endtask
	task automatic load(input logic [15:0] v);
		load_val <= v;
		load_en <= 1'h1;
		go(1);
		load_en <= 1'h0;
	endtask
	// Pulses on the pin away from its idle level
	task automatic edges(input int k, input logic idle);
		repeat (k) begin
			pin_req <= ~idle;
			go(3);
			pin_req <= idle;
			go(3);
		end
	endtask

	initial begin
		go(2);
		reset <= 1'h0;
		go(1);
		// Reset values and an unmapped place
		bus(0, ECC_ADDR_CTRL, 8'h00);
		chk("ctrl reset", ECC_CTRL_RESET, q);
		chk("oe_n reset", 4'hF, pins.oe_n);
		bus(1, 8'h10, 8'hA5);
		bus(0, 8'h10, 8'h00);
		chk("unmapped", 0, q);
		// Capture modes, two captures each
		for (int m = 4; m < 8; m++) begin
			n = (m == 6) ? 4 : (m == 7) ? 16 : 1;
			bus(1, ECC_ADDR_CTRL, 8'h00);
			pin_req <= (m == 4);
			bus(1, ECC_ADDR_CTRL, {4'hC, m[3:0]});
			bus(0, ECC_ADDR_CTRL, 8'h00);
			chk("ctrl", {4'hC, m[3:0]}, q);
			go(6);
			bus(1, ECC_ADDR_STAT, 8'h01);
			chk("released", 3'h7, pins.oe_n[3:1]);
			repeat (2) begin
				tval = 16'(rnd());
				load(tval);
				edges(n - 1, m == 4);
				chk("early flag", 0, flag);
				edges(1, m == 4);
				chk("flag", 1, flag);
				bus(0, ECC_ADDR_CCLO, 8'h00);
				chk("cap lo", tval[7:0], q);
				bus(0, ECC_ADDR_CCHI, 8'h00);
				chk("cap hi", tval[15:8], q);
				chk("flag kept", 1, flag);
				bus(1, ECC_ADDR_STAT, 8'h01);
				go(1);
				chk("flag clr", 0, flag);
			end
		end
		// Prescaler kept across a direct setting change
		bus(1, ECC_ADDR_CTRL, 8'h07);
		edges(2, 0);
		bus(1, ECC_ADDR_CTRL, 8'h06);
		bus(1, ECC_ADDR_STAT, 8'h01);
		edges(2, 0);
		chk("kept presc", 1, flag);
		bus(1, ECC_ADDR_STAT, 8'h01);
		// Compare modes against a running timer
		bus(1, ECC_ADDR_CTRL, 8'h00);
		tval = (16'(rnd()) & 16'h7FF0) | 16'h0010;
		bus(1, ECC_ADDR_CCLO, tval[7:0]);
		bus(1, ECC_ADDR_CCHI, tval[15:8]);
		lvl = 0;
		for (int i = 0; i < 7; i++) begin
			adc_enabled <= (i == 5);
			bus(1, ECC_ADDR_CTRL, 8'(cmp_modes[i]));
			a0 = n_adc;
			t0 = n_trst;
			load(tval - 16'h0003);
			count_en <= 1'h1;
			go(12);
			count_en <= 1'h0;
			go(2);
			chk("cmp flag", 1, flag);
			lvl = (cmp_modes[i] == 8) ? 1 : (cmp_modes[i] == 9) ? 0 : (cmp_modes[i] == 2) ? 1 - lvl : lvl;
			if (cmp_modes[i] < 10)
				chk("cmp pin", lvl, pins.level[0]);
			else
				chk("cmp pin free", 1, pins.oe_n[0]);
			if (cmp_modes[i] == 11) begin
				chk("timer reset", 1, n_trst - t0);
				chk("timer period", 2, tcount);
				chk("adc start", int'(i == 5), n_adc - a0);
			end
			bus(1, ECC_ADDR_STAT, 8'h01);
		end
		bus(1, ECC_ADDR_CTRL, 8'h00);
		go(2);
		chk("latch off", 0, pins.level[0]);
		// PWM polarity, steering and duty
		cc_lo = 8'(rnd());
		bus(1, ECC_ADDR_CCLO, cc_lo);
		for (int k = 0; k < 32; k++) begin
			w = k[4];
			ac = k[1];
			bd = k[0];
			wave_req <= w;
			bus(1, ECC_ADDR_CTRL, {k[3:2], k[4:3], 2'h3, k[1:0]});
			go(4);
			oe = (k[3:2] == 0) ? 4'hE : (k[3:2] == 2) ? 4'hC : 4'h0;
			case (k[3:2])
				0: lv = {3'h0, w ^ ac};
				1: lv = {w ^ bd, ac, bd, ~ac};
				2: lv = {2'h0, ~w ^ bd, w ^ ac};
				default: lv = {bd, ~ac, w ^ bd, ac};
			endcase
			chk("oe_n", oe, pins.oe_n);
			chk("level", lv & ~oe, pins.level & ~oe);
			chk("duty", {cc_lo, k[4:3]}, duty_value);
		end
		bus(1, ECC_ADDR_CTRL, 8'h00);
		go(2);
		chk("off oe_n", 4'hF, pins.oe_n);
		chk("off duty", 0, duty_value);
		wrap_up();
	end
endmodule
`default_nettype wire
